// *** hdl/conv_control.sv ***
`timescale 1ns/10ps
module conv_control
	import tsense_pkg::*;
#(
	parameter int unsigned AUTO_CYCLES = AUTO_PERIOD_CYCLES
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Pins
	input  wire logic              conversion_start_pin,
	input  wire logic [2:0]        addr_pins,
	input  wire logic              por_load_fail,
	// Converter
	input  wire logic              conv_done,
	input  wire logic [9:0]        conv_data,
	output conv_ctrl_t             conv_ctrl
);

	localparam logic [AUTO_CNT_W-1:0] AUTO_LOAD = AUTO_CNT_W'(AUTO_CYCLES - 1);

	// ==========================================
	// Pin synchronisers
	logic [4:0] pins_s;
	logic       pin_s;
	logic [2:0] addr_s;
	logic       fail_s;

	sync2 #(
		.W (5)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({por_load_fail, addr_pins, conversion_start_pin}),
		.q       (pins_s)
	);

	assign pin_s  = pins_s[0];
	assign addr_s = pins_s[3:1];
	assign fail_s = pins_s[4];

	// ==========================================
	// State
	logic [7:0]            config_r,   config_nxt;
	logic [7:0]            secondary_configuration_register_r,  secondary_configuration_register_nxt;
	logic [15:0]           hyst_r,     hyst_nxt;
	logic [15:0]           trip_r,     trip_nxt;
	logic [9:0]            result_r,   result_nxt;
	logic [6:0]            busaddr_r,  busaddr_nxt;
	logic [3:0]            written_r,  written_nxt;
	logic                  valid_r,    valid_nxt;
	logic                  oneshot_r,  oneshot_nxt;
	logic [1:0]            init_r,     init_nxt;
	logic                  pin_d_r,    pin_d_nxt;
	logic [TMR_W-1:0]      tmr_r,      tmr_nxt;
	logic [AUTO_CNT_W-1:0] auto_r,     auto_nxt;
	conv_state_t           state_r,    state_nxt;
	conv_ctrl_t            ctrl_r,     ctrl_nxt;
	logic [31:0]           prdata_r,   prdata_nxt;
	logic                  pready_r,   pready_nxt;
	logic                  pslverr_r,  pslverr_nxt;

	logic        setup;
	logic        wr_fire;
	logic        addr_ok;
	logic [31:0] rd_data;
	logic        pin_mode;
	logic        auto_en;
	logic        rise;
	logic        fall;

	assign pin_mode = secondary_configuration_register_r[CFG2_PIN_MODE_BIT];
	assign auto_en  = !pin_mode && !config_r[CFG_SHUTDOWN_BIT];
	assign rise     = pin_s && !pin_d_r;
	assign fall     = !pin_s && pin_d_r;
	assign setup    = psel && !penable;
	assign wr_fire  = psel && penable && pready_r && pwrite && addr_ok;

	// ==========================================
	// Register read decode
	always_comb begin
		rd_data = 32'h0000_0000;
		addr_ok = 1'b1;
		if (paddr == OFF_CONFIG) begin
			rd_data[7:0] = config_r;
		end else if (paddr == OFF_SECONDARY_CONFIGURATION_REGISTER) begin
			rd_data[7:0] = secondary_configuration_register_r;
		end else if (paddr == OFF_HYST) begin
			rd_data[15:0] = hyst_r;
		end else if (paddr == OFF_TRIP) begin
			rd_data[15:0] = trip_r;
		end else if (paddr == OFF_STATUS) begin
			rd_data[2:0]            = state_r;
			rd_data[STAT_VALID_BIT] = valid_r;
			rd_data[STAT_PIN_BIT]   = pin_mode;
		end else if (paddr == OFF_RESULT) begin
			rd_data[9:0] = result_r;
		end else if (paddr == OFF_BUSADDR) begin
			rd_data[6:0] = busaddr_r;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ==========================================
	// APB answer
	always_comb begin
		pready_nxt  = setup;
		pslverr_nxt = setup && !addr_ok;
		prdata_nxt  = (setup && !pwrite) ? rd_data : prdata_r;
	end

	// ==========================================
	// Register writes
	always_comb begin
		config_nxt  = config_r;
		secondary_configuration_register_nxt = secondary_configuration_register_r;
		hyst_nxt    = hyst_r;
		trip_nxt    = trip_r;
		written_nxt = written_r;
		busaddr_nxt = {BUS_ADDR_HI, addr_s};
		if (wr_fire) begin
			if (paddr == OFF_CONFIG) begin
				config_nxt                 = pwdata[7:0];
				written_nxt[WR_CONFIG_BIT] = 1'b1;
			end else if (paddr == OFF_SECONDARY_CONFIGURATION_REGISTER) begin
				secondary_configuration_register_nxt                 = pwdata[7:0];
				written_nxt[WR_SECONDARY_CONFIGURATION_REGISTER_BIT] = 1'b1;
			end else if (paddr == OFF_HYST) begin
				hyst_nxt                 = pwdata[15:0];
				written_nxt[WR_HYST_BIT] = 1'b1;
			end else if (paddr == OFF_TRIP) begin
				trip_nxt                 = pwdata[15:0];
				written_nxt[WR_TRIP_BIT] = 1'b1;
			end
		end
	end

	// ==========================================
	// Conversion sequencing
	always_comb begin
		state_nxt   = state_r;
		ctrl_nxt    = ctrl_r;
		tmr_nxt     = tmr_r;
		auto_nxt    = auto_r;
		valid_nxt   = valid_r;
		init_nxt    = init_r;
		oneshot_nxt = oneshot_r;
		result_nxt  = result_r;
		pin_d_nxt   = pin_s;
		ctrl_nxt.start = 1'b0;

		if (written_r == WR_ALL) begin
			valid_nxt = 1'b1;
		end

		// Periodic timer, counts only in auto mode
		if (!auto_en || !valid_r) begin
			auto_nxt = AUTO_LOAD;
		end else if (auto_r != '0) begin
			auto_nxt = auto_r - AUTO_CNT_W'(1);
		end

		case (state_r)
			ST_INIT: begin
				ctrl_nxt = '0;
				if (init_r != INIT_DONE) begin
					init_nxt = init_r + 2'h1;
				end else if (!fail_s || valid_r) begin
					valid_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				ctrl_nxt = '0;
				if (pin_mode) begin
					oneshot_nxt = 1'b0;
					if (rise) begin
						tmr_nxt           = POWERUP_LOAD;
						ctrl_nxt.power_up = 1'b1;
						state_nxt         = ST_POWERUP;
					end
				end else if ((auto_en && auto_r == '0) || oneshot_r) begin
					oneshot_nxt = 1'b0;
					auto_nxt    = AUTO_LOAD;
					ctrl_nxt    = '{power_up: 1'b1, hold: 1'b1, start: 1'b1};
					state_nxt   = ST_CONVERT;
				end
			end
			ST_POWERUP: begin
				if (tmr_r != '0) begin
					tmr_nxt = tmr_r - TMR_W'(1);
				end else if (pin_s) begin
					state_nxt = ST_WAIT_FALL;
				end else begin
					ctrl_nxt.hold  = 1'b1;
					ctrl_nxt.start = 1'b1;
					state_nxt      = ST_CONVERT;
				end
			end
			ST_WAIT_FALL: begin
				if (fall) begin
					ctrl_nxt.hold  = 1'b1;
					ctrl_nxt.start = 1'b1;
					state_nxt      = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (conv_done) begin
					result_nxt = conv_data;
					ctrl_nxt   = '0;
					state_nxt  = ST_IDLE;
				end
			end
			default: begin
				ctrl_nxt  = '0;
				state_nxt = ST_INIT;
			end
		endcase

		// One conversion per config write while shut down
		// After the case so a new request beats the idle clear
		if (wr_fire && paddr == OFF_CONFIG && pwdata[CFG_SHUTDOWN_BIT] && !pin_mode) begin
			oneshot_nxt = 1'b1;
		end
	end

	// ==========================================
	// APB answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ==========================================
	// Register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_r  <= CONFIG_RST;
			secondary_configuration_register_r <= SECONDARY_CONFIGURATION_REGISTER_RST;
			hyst_r    <= HYST_RST;
			trip_r    <= TRIP_RST;
			busaddr_r <= 7'h00;
			written_r <= 4'h0;
		end else begin
			config_r  <= config_nxt;
			secondary_configuration_register_r <= secondary_configuration_register_nxt;
			hyst_r    <= hyst_nxt;
			trip_r    <= trip_nxt;
			busaddr_r <= busaddr_nxt;
			written_r <= written_nxt;
		end
	end

	// ==========================================
	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_r  <= RESULT_RST;
			valid_r   <= 1'b0;
			oneshot_r <= 1'b0;
			init_r    <= 2'h0;
			pin_d_r   <= 1'b0;
			tmr_r     <= '0;
			auto_r    <= '0;
			state_r   <= ST_INIT;
			ctrl_r    <= '0;
		end else begin
			result_r  <= result_nxt;
			valid_r   <= valid_nxt;
			oneshot_r <= oneshot_nxt;
			init_r    <= init_nxt;
			pin_d_r   <= pin_d_nxt;
			tmr_r     <= tmr_nxt;
			auto_r    <= auto_nxt;
			state_r   <= state_nxt;
			ctrl_r    <= ctrl_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;
	assign conv_ctrl = ctrl_r;

endmodule

// *** hdl/tsense_pkg.sv ***
package tsense_pkg;

	// ==========================================
	// Timing
	localparam int CLK_MHZ            = 200;
	localparam int POWERUP_NS         = 4000;
	localparam int POWERUP_CYCLES     = (POWERUP_NS * CLK_MHZ + 999) / 1000;
	localparam int AUTO_PERIOD_US     = 400;
	localparam int AUTO_PERIOD_CYCLES = AUTO_PERIOD_US * CLK_MHZ;
	localparam int AUTO_CNT_W         = 17;
	localparam int TMR_W              = 10;
	localparam logic [TMR_W-1:0] POWERUP_LOAD = TMR_W'(POWERUP_CYCLES - 1);
	localparam logic [1:0] INIT_DONE  = 2'h3;

	// ==========================================
	// Register offsets
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_CONFIG  = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_SECONDARY_CONFIGURATION_REGISTER = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_HYST    = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_TRIP    = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_RESULT  = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_BUSADDR = 12'h018;

	// ==========================================
	// Fields and reset values
	localparam int CFG_SHUTDOWN_BIT   = 0;
	localparam int CFG2_PIN_MODE_BIT  = 7;
	localparam logic [7:0]  CONFIG_RST  = 8'h00;
	localparam logic [7:0]  SECONDARY_CONFIGURATION_REGISTER_RST = 8'h00;
	localparam logic [15:0] HYST_RST    = 16'h4B00;
	localparam logic [15:0] TRIP_RST    = 16'h5500;
	localparam logic [9:0]  RESULT_RST  = 10'h000;
	localparam logic [3:0]  BUS_ADDR_HI = 4'h9;
	localparam int WR_CONFIG_BIT  = 0;
	localparam int WR_SECONDARY_CONFIGURATION_REGISTER_BIT = 1;
	localparam int WR_HYST_BIT    = 2;
	localparam int WR_TRIP_BIT    = 3;
	localparam logic [3:0] WR_ALL = 4'hF;
	localparam int STAT_VALID_BIT = 3;
	localparam int STAT_PIN_BIT   = 4;

	// ==========================================
	// Types
	typedef enum logic [2:0] {
		ST_INIT,
		ST_IDLE,
		ST_POWERUP,
		ST_WAIT_FALL,
		ST_CONVERT
	} conv_state_t;

	typedef struct packed {
		logic power_up;
		logic hold;
		logic start;
	} conv_ctrl_t;

endpackage

// *** hdl/sync2.sv ***
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end

endmodule

// *** bench/conv_model.sv ***
`timescale 1ns/10ps
module conv_model
	import tsense_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Converter
	input  wire conv_ctrl_t conv_ctrl,
	output logic            conv_done,
	output logic [9:0]      conv_data
);
	// ==========================================
	// Busy 20 cycles, data toggles every cycle except one load of 2A5 just before done
	logic [4:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r     <= 5'h00;
			conv_data <= 10'h000;
		end else begin
			conv_data <= (cnt_r == 5'h02) ? 10'h2A5 : ~conv_data;
			if (conv_ctrl.start)
				cnt_r <= 5'h14;
			else if (cnt_r != 5'h00)
				cnt_r <= cnt_r - 5'h01;
		end
	end
	assign conv_done = (cnt_r == 5'h01);
endmodule

// *** bench/conv_control_monitor.sv ***
`timescale 1ns/10ps
module conv_control_monitor
	import tsense_pkg::*;
(
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// Bus and converter
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              conv_done,
	input wire conv_ctrl_t        conv_ctrl
);
	// ==========================================
	// Power-up cycle counter
	logic [10:0] pu_r;
	logic [10:0] pu_nxt;
	always_comb begin
		pu_nxt = 11'h000;
		if (conv_ctrl.power_up && !conv_ctrl.hold)
			pu_nxt = pu_r + 11'h001;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pu_r <= 11'h000;
		else
			pu_r <= pu_nxt;
	end
	// ==========================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_finish;
		conv_done && conv_ctrl.hold;
	endsequence
	a_ready_next: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_map: assert property (pready |->
		pslverr == (paddr > OFF_BUSADDR || paddr[1:0] != 2'h0))
		else $error("pslverr wrong for address");
	a_start_pulse: assert property (conv_ctrl.start |=> !conv_ctrl.start)
		else $error("start longer than one cycle");
	a_hold_start: assert property ($rose(conv_ctrl.hold) |-> conv_ctrl.start)
		else $error("hold rose without start");
	a_powerup_time: assert property ($rose(conv_ctrl.hold) |->
		pu_r == 11'h000 || pu_r >= 11'(POWERUP_CYCLES))
		else $error("hold before power-up time");
	a_done_off: assert property (s_finish |=> conv_ctrl == 3'h0)
		else $error("no power down after done");
	a_hold_stands: assert property (conv_ctrl.hold && !conv_done |=> conv_ctrl.hold)
		else $error("hold dropped early");
endmodule
bind conv_control conv_control_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.conv_done(conv_done), .conv_ctrl(conv_ctrl));

// *** bench/conv_control_test.sv ***
`timescale 1ns/10ps
module conv_control_test
	import tsense_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, pin, fail, done, er;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr;
	logic [2:0]        straps;
	logic [9:0]        cdata;
	conv_ctrl_t        ctrl;
	int                error_cnt, comparisons, n;
	localparam logic [ADDR_W-1:0] DA [4] = '{OFF_CONFIG, OFF_SECONDARY_CONFIGURATION_REGISTER, OFF_HYST, OFF_TRIP};
	localparam logic [31:0] DV [4] = '{32'h0, 32'h0, 32'h4B00, 32'h5500};
	localparam int AUTO_SIM = 200;
	always #2.5 pclk = ~pclk;
	conv_control #(.AUTO_CYCLES(AUTO_SIM)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conversion_start_pin(pin), .addr_pins(straps), .por_load_fail(fail),
		.conv_done(done), .conv_data(cdata), .conv_ctrl(ctrl));
	conv_model model (.pclk(pclk), .presetn(presetn), .conv_ctrl(ctrl),
		.conv_done(done), .conv_data(cdata));
	// ==========================================
	// Shared tasks
	task automatic summarize();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic wait_start(input int bound, input logic want);
		n = 0;
		while (ctrl.start !== 1'b1 && n <= bound) begin
			@(posedge pclk);
			n++;
		end
		if (want && n > bound) begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic pulse(input int hi);
		@(posedge pclk);
		pin <= 1'b1;
		n = 0;
		while (ctrl.start !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
			if (n == hi)
				pin <= 1'b0;
		end
		if (n >= 3000) begin
			error_cnt++;
			summarize();
		end
	endtask
	// ==========================================
	// Scenarios
	task automatic t_defaults();
		apb(1'b0, OFF_STATUS, 32'h0);
		check(rd, 32'h9);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, DA[i], 32'h0);
			check(rd, DV[i]);
		end
		apb(1'b0, 12'h100, 32'h0);
		check({rd[30:0], er}, 32'h1);
		for (int i = 0; i < 8; i += 7) begin
			straps <= 3'(i);
			apb(1'b0, OFF_BUSADDR, 32'h0);
			apb(1'b0, OFF_BUSADDR, 32'h0);
			check(rd, 32'h48 + 32'(i));
		end
	endtask
	task automatic t_auto();
		wait_start(300, 1'b1);
		check(32'(n > 300), 32'h0);
		@(posedge pclk);
		wait_start(300, 1'b1);
		check(32'(n), 32'(AUTO_SIM - 1));
		repeat (30) @(posedge pclk);
		apb(1'b0, OFF_RESULT, 32'h0);
		check(rd, 32'h2A5);
	endtask
	task automatic t_pin();
		apb(1'b1, OFF_SECONDARY_CONFIGURATION_REGISTER, 32'h80);
		apb(1'b0, OFF_STATUS, 32'h0);
		check(32'(rd[4]), 32'h1);
		repeat (30) @(posedge pclk);
		wait_start(400, 1'b0);
		check(32'(n > 400), 32'h1);
		pulse(10);
		check(32'(n >= 800 && n <= 806), 32'h1);
		repeat (30) @(posedge pclk);
		check(32'(ctrl), 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		check(32'(rd[2:0]), 32'h1);
		pulse(1000);
		check(32'(n >= 1000 && n <= 1006), 32'h1);
		repeat (30) @(posedge pclk);
	endtask
	task automatic t_por();
		fail <= 1'b1;
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_start(300, 1'b0);
		check(32'(n > 300), 32'h1);
		apb(1'b0, OFF_RESULT, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		check(32'(rd[3:0]), 32'h0);
		for (int i = 0; i < 4; i++)
			apb(1'b1, DA[i], DV[i]);
		repeat (2) @(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0);
		check(32'(rd[3:0]), 32'h9);
		wait_start(300, 1'b1);
		check(32'(n > 300), 32'h0);
	endtask
	initial begin
		{pclk, presetn, psel, penable, pwrite, pin, fail} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		straps = 3'h5;
		error_cnt = 0;
		comparisons = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		t_defaults();
		t_auto();
		t_pin();
		t_por();
		summarize();
	end
endmodule
